// >>> xis_pkg.sv
// Constants for the exchange, XOR and increment-with-skip instruction block
// Function
// - Swap working register with RAM nibble addressed by data_pointer.
// - Write RAM file pointer with its old value XOR the 4-bit immediate.
// - Increment RAM digit pointer by one, wrapping modulo sixteen.
// - When incremented digit pointer is zero, skip the following instruction.
package xis_pkg;
  localparam int NIB_W = 4;
  localparam int RAM_ADDR_W = 8;
  localparam logic [3:0] NIB_RESET = 4'h0;
  localparam logic [3:0] DIGIT_WRAP = 4'h0;
  localparam logic [3:0] DIGIT_STEP = 4'h1;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  typedef enum logic [1:0] {
    XIS_IDLE = 2'b00,
    XIS_READ = 2'b01,
    XIS_WRITE = 2'b10
  } xis_state_type;
endpackage

// >>> xis_ram_if.sv
// Interface carrying the data RAM nibble port between the block and its memory
`timescale 1ns/1ns
`default_nettype none
interface xis_ram_if;
  logic [7:0] addr;
  logic wr_en;
  logic [3:0] wr_data;
  logic [3:0] rd_data;
  modport ctrl (output addr, output wr_en, output wr_data, input rd_data);
  modport mem (input addr, input wr_en, input wr_data, output rd_data);
endinterface
`default_nettype wire

// >>> xis_ram.sv
// Nibble-wide data RAM with registered read data
`timescale 1ns/1ns
`default_nettype none
module xis_ram #(
  parameter int DEPTH = 256
) (
  // Clock
  input wire logic clock,
  // Port
  xis_ram_if.mem port
);
  logic [3:0] mem_q [DEPTH];
  always_ff @(posedge clock) begin
    if (port.wr_en) begin
      mem_q[port.addr] <= port.wr_data;
    end
  end
  always_ff @(posedge clock) begin
    port.rd_data <= mem_q[port.addr];
  end
endmodule // xis_ram
`default_nettype wire

// >>> xis_exec.sv
// Execution unit for the exchange, XOR and increment-with-skip instruction
`timescale 1ns/1ns
`default_nettype none
module xis_exec (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Instruction request
  input wire logic start,
  input wire logic [3:0] imm,
  // Register preload
  input wire logic load,
  input wire logic [3:0] load_acc,
  input wire logic [3:0] load_file,
  input wire logic [3:0] load_digit,
  // RAM preload
  input wire logic ram_load,
  input wire logic [3:0] ram_load_data,
  // Register state
  output logic [3:0] acc_q,
  output logic [3:0] file_q,
  output logic [3:0] digit_q,
  // Completion
  output logic done_q,
  output logic skip_q
);
  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  xis_ram_if ram ();

  xis_ram #(
    .DEPTH(256)
  ) xis_ram_inst (
    .clock(clock),
    .port(ram.mem)
  );

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  xis_pkg::xis_state_type state_q;
  xis_pkg::xis_state_type state_d;
  logic [3:0] imm_q;
  logic [3:0] imm_d;
  logic [3:0] acc_d;
  logic [3:0] file_d;
  logic [3:0] digit_d;
  logic done_d;
  logic skip_d;
  logic [3:0] next_digit;
  logic [3:0] next_file;
  logic in_idle;
  logic in_read;
  logic in_write;
  logic take_start;
  logic take_load;
  logic take_ram_load;
  logic wraps;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  assign in_idle = (state_q == xis_pkg::XIS_IDLE);
  assign in_read = (state_q == xis_pkg::XIS_READ);
  assign in_write = (state_q == xis_pkg::XIS_WRITE);
  assign take_start = start && in_idle;
  assign take_load = load && in_idle;
  assign take_ram_load = ram_load && in_idle;

  // data_pointer is the file and digit pointers concatenated
  assign ram.addr = {file_q, digit_q};

  assign next_digit = digit_q + xis_pkg::DIGIT_STEP;
  assign wraps = (next_digit == xis_pkg::DIGIT_WRAP);

  // Per-bit exclusive OR of the file pointer with the latched immediate
  for (genvar b = 0; b < xis_pkg::NIB_W; b++) begin : g_file_xor
    assign next_file[b] = file_q[b] ^ imm_q[b];
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      xis_pkg::XIS_IDLE: begin
        if (start) begin
          state_d = xis_pkg::XIS_READ;
        end
      end
      xis_pkg::XIS_READ: begin
        state_d = xis_pkg::XIS_WRITE;
      end
      xis_pkg::XIS_WRITE: begin
        state_d = xis_pkg::XIS_IDLE;
      end
      default: begin
        state_d = xis_pkg::XIS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= xis_pkg::XIS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ------------------------------------------------------------
  // Immediate
  // ------------------------------------------------------------
  // Latched so that the pin may change while the instruction runs
  always_comb begin
    imm_d = imm_q;
    if (take_start) begin
      imm_d = imm;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      imm_q <= xis_pkg::NIB_RESET;
    end else begin
      imm_q <= imm_d;
    end
  end

  // ------------------------------------------------------------
  // RAM write: old working register goes to M(data_pointer)
  // ------------------------------------------------------------
  // Read data of the old address was registered during the read state
  always_comb begin
    ram.wr_en = in_write || take_ram_load;
    ram.wr_data = in_write ? acc_q : ram_load_data;
  end

  // ------------------------------------------------------------
  // Working register
  // ------------------------------------------------------------
  always_comb begin
    acc_d = acc_q;
    if (in_write) begin
      acc_d = ram.rd_data;
    end else if (take_load) begin
      acc_d = load_acc;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      acc_q <= xis_pkg::NIB_RESET;
    end else begin
      acc_q <= acc_d;
    end
  end

  // ------------------------------------------------------------
  // Pointers
  // ------------------------------------------------------------
  // Pointers update with the RAM write so the swap uses the old address
  always_comb begin
    file_d = file_q;
    if (in_write) begin
      file_d = next_file;
    end else if (take_load) begin
      file_d = load_file;
    end
  end

  always_comb begin
    digit_d = digit_q;
    if (in_write) begin
      digit_d = next_digit;
    end else if (take_load) begin
      digit_d = load_digit;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      file_q <= xis_pkg::NIB_RESET;
    end else begin
      file_q <= file_d;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      digit_q <= xis_pkg::NIB_RESET;
    end else begin
      digit_q <= digit_d;
    end
  end

  // ------------------------------------------------------------
  // Completion and skip
  // ------------------------------------------------------------
  // Skip is a pulse beside done; the fetch side acts on it
  always_comb begin
    done_d = in_write && !in_read;
    skip_d = in_write && wraps;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_d;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      skip_q <= 1'b0;
    end else begin
      skip_q <= skip_d;
    end
  end
endmodule // xis_exec
`default_nettype wire

// >>> xis_exec_asserts.sv
// Assertions of the exchange, XOR and increment block
`timescale 1ns/1ns
`default_nettype none
module xis_exec_asserts (
  // Clock, reset, request
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire logic [3:0] imm,
  // State
  input wire logic [3:0] file_q,
  input wire logic [3:0] digit_q,
  input wire logic done_q,
  input wire logic skip_q
);
  // Mirrors the busy window seen at the ports; starts inside it are ignored
  logic [1:0] busy_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_q <= 2'd0;
    end else if (start && busy_q == 2'd0) begin
      busy_q <= 2'd2;
    end else if (busy_q != 2'd0) begin
      busy_q <= busy_q - 2'd1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_done_delay: assert property (start && busy_q == 2'd0 |-> ##3 done_q) else $error("done late");
  chk_done_pulse: assert property (done_q |=> !done_q) else $error("done not a pulse");
  chk_skip_done: assert property (skip_q |-> done_q) else $error("skip without done");
  chk_file_xor: assert property (done_q |-> file_q == ($past(file_q, 3) ^ $past(imm, 3))) else $error("file");
  chk_digit_inc: assert property (done_q |-> digit_q == $past(digit_q, 3) + 4'h1) else $error("digit");
  chk_skip_wrap: assert property (done_q && digit_q == 4'h0 |-> skip_q) else $error("no skip");
  chk_no_skip: assert property (done_q && digit_q != 4'h0 |-> !skip_q) else $error("skip");
endmodule // xis_exec_asserts
bind xis_exec xis_exec_asserts xis_exec_asserts_inst (.clock, .rst, .start, .imm, .file_q, .digit_q, .done_q, .skip_q);
`default_nettype wire

// >>> tb_xis_exec.sv
// Testbench of the exchange, XOR and increment block
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin n_errors++; $display("ERROR %s exp %h got %h", n, e, s); end end
module tb_xis_exec;
  logic clock = 0, rst = 1, start = 0, load = 0, ram_load = 0, done_q, skip_q;
  logic [3:0] imm = 0, load_acc = 0, load_file = 0, load_digit = 0, ram_load_data = 0, acc_q, file_q, digit_q;
  logic [23:0] r;
  int n_errors = 0, n_compared = 0;
  // Rows: acc, file, digit, RAM nibble, immediate, RAM write flag in bit 3, skip in bit 0
  logic [23:0] rows [4] = '{24'hC3_FA69, 24'h10_07F8, 24'hFF_E008, 24'h69_7598};
  xis_exec xis_exec_inst (.clock, .rst, .start, .imm, .load, .load_acc, .load_file, .load_digit, .ram_load,
    .ram_load_data, .acc_q, .file_q, .digit_q, .done_q, .skip_q);
  initial forever #2 clock = ~clock;
  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic op(input logic [23:0] v);
    int k = 0;
    @(posedge clock);
    {load, load_acc, load_file, load_digit} <= {1'b1, v[23:12]};
    @(posedge clock);
    {load, ram_load, ram_load_data} <= {1'b0, v[3], v[11:8]};
    @(posedge clock);
    {ram_load, start, imm} <= {1'b0, 1'b1, v[7:4]};
    @(posedge clock);
    start <= 0;
    #1;
    while (done_q !== 1'b1 && k < 8) begin
      @(posedge clock) #1;
      k++;
    end
    if (k == 8) begin
      n_errors++;
      final_report();
    end
  endtask
  initial begin
    repeat (4) @(posedge clock);
    `CHK("reset", 14'h0, {acc_q, file_q, digit_q, done_q, skip_q})
    rst <= 0;
    foreach (rows[i]) begin
      r = rows[i];
      op(r);
      `CHK("acc", r[11:8], acc_q)
      `CHK("file", r[19:16] ^ r[7:4], file_q)
      `CHK("digit", r[15:12] + 4'h1, digit_q)
      `CHK("skip", r[0], skip_q)
      op({4'h0, r[19:12], 12'h000});
      `CHK("swap", r[23:20], acc_q)
      $display("row %0d done", i);
    end
    // Busy: a start, a preload and a RAM preload inside the instruction are ignored
    @(posedge clock);
    {load, load_acc, load_file, load_digit} <= 13'h1_2AF;
    @(posedge clock);
    {load, ram_load, ram_load_data} <= 6'h17;
    @(posedge clock);
    {ram_load, start, imm} <= 6'h15;
    @(posedge clock);
    load <= 1'b1;
    load_acc <= 4'h9;
    ram_load <= 1'b1;
    ram_load_data <= 4'h1;
    @(posedge clock);
    {start, load, ram_load} <= 3'b000;
    @(posedge clock) #1;
    `CHK("busy done", 1'b1, done_q)
    `CHK("busy acc", 4'h7, acc_q)
    `CHK("busy file", 4'hF, file_q)
    `CHK("busy digit", 4'h0, digit_q)
    `CHK("busy skip", 1'b1, skip_q)
    $display("busy test done");
    // Reset in mid-instruction
    @(posedge clock);
    start <= 1'b1;
    @(posedge clock);
    {start, rst} <= 2'b01;
    @(posedge clock) #1;
    `CHK("mid reset", 14'h0, {acc_q, file_q, digit_q, done_q, skip_q})
    @(posedge clock);
    rst <= 1'b0;
    op(24'h10_07F8);
    `CHK("after reset acc", 4'h7, acc_q)
    `CHK("after reset file", 4'hF, file_q)
    `CHK("after reset digit", 4'h1, digit_q)
    `CHK("after reset skip", 1'b0, skip_q)
    $display("reset test done");
    final_report();
  end
endmodule // tb_xis_exec
`default_nettype wire
